// ==== pshx_pkg.sv ====
// pshx_pkg: shared constants, types and helpers for the pressure scan hex output block
// assumes a single 40 MHz system clock domain
package pshx_pkg;

   // ------------------------------------------------------------
   // clock and serial timing
   // ------------------------------------------------------------
   localparam int CLK_HZ = 40_000_000;
   localparam int BAUD_1200 = 1200;
   localparam int BAUD_2400 = 2400;
   localparam int BAUD_4800 = 4800;
   localparam int BAUD_9600 = 9600;
   localparam int BAUD_19200 = 19200;
   localparam int DIV_W = 16;
   localparam logic [DIV_W-1:0] DIV_1200 = DIV_W'(CLK_HZ / BAUD_1200);
   localparam logic [DIV_W-1:0] DIV_2400 = DIV_W'(CLK_HZ / BAUD_2400);
   localparam logic [DIV_W-1:0] DIV_4800 = DIV_W'(CLK_HZ / BAUD_4800);
   localparam logic [DIV_W-1:0] DIV_9600 = DIV_W'(CLK_HZ / BAUD_9600);
   localparam logic [DIV_W-1:0] DIV_19200 = DIV_W'(CLK_HZ / BAUD_19200);

   // ------------------------------------------------------------
   // line rate selection codes
   // ------------------------------------------------------------
   localparam logic [2:0] RATE_1200 = 3'h0;
   localparam logic [2:0] RATE_2400 = 3'h1;
   localparam logic [2:0] RATE_4800 = 3'h2;
   localparam logic [2:0] RATE_9600 = 3'h3;
   localparam logic [2:0] RATE_19200 = 3'h4;

   // ------------------------------------------------------------
   // character framing
   // ------------------------------------------------------------
   localparam int CHAR_W = 8;
   localparam int DATA_BITS = 8;
   localparam int FIFO_DEPTH = 8;
   localparam logic [3:0] LINE_LAST = 4'ha;
   localparam logic [3:0] IDX_CR = 4'h9;
   localparam logic [7:0] CHAR_CR = 8'h0d;
   localparam logic [7:0] CHAR_LF = 8'h0a;
   localparam logic [7:0] CHAR_ZERO = 8'h30;
   localparam logic [7:0] CHAR_UPPER_A = 8'h41;
   localparam logic [3:0] NIBBLE_TEN = 4'ha;
   localparam logic [3:0] BIT_LAST = 4'h7;

   // one raw pressure scan
   typedef struct packed {
      logic [7:0] freq_hi;
      logic [7:0] freq_lo;
      logic [7:0] freq_frac;
      logic [11:0] temp_comp;
   } pshx_scan_s;

   typedef enum logic [1:0] {
      PSHX_TX_IDLE,
      PSHX_TX_START,
      PSHX_TX_DATA,
      PSHX_TX_STOP
   } pshx_tx_e;

   typedef enum logic [1:0] {
      PSHX_RX_IDLE,
      PSHX_RX_START,
      PSHX_RX_DATA,
      PSHX_RX_STOP
   } pshx_rx_e;

   // nibble to upper-case ascii hex
   function automatic logic [7:0] pshx_hex(input logic [3:0] nib);
      if (nib < NIBBLE_TEN) begin
         pshx_hex = CHAR_ZERO + {4'h0, nib};
      end else begin
         pshx_hex = CHAR_UPPER_A + {4'h0, nib - NIBBLE_TEN};
      end
   endfunction : pshx_hex

   // bit period in clocks for a rate code, unknown codes fall back to 9600
   function automatic logic [DIV_W-1:0] pshx_div(input logic [2:0] code);
      case (code)
         RATE_1200: pshx_div = DIV_1200;
         RATE_2400: pshx_div = DIV_2400;
         RATE_4800: pshx_div = DIV_4800;
         RATE_19200: pshx_div = DIV_19200;
         default: pshx_div = DIV_9600;
      endcase
   endfunction : pshx_div

endpackage : pshx_pkg

// ==== pshx_fifo.sv ====
// pshx_fifo: flip-flop fifo with valid/ready on both sides
// assumes one clock, synchronous active-high reset
`timescale 1ns/100ps
module pshx_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic sys_rst,
   // fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int PW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [PW-1:0] wr_ptr_r;
   logic [PW-1:0] rd_ptr_r;
   logic [PW:0] count_r;
   logic push;
   logic pop;

   // ------------------------------------------------------------
   // handshakes
   // ------------------------------------------------------------
   assign in_ready = (count_r != (PW+1)'(DEPTH));
   assign out_valid = (count_r != '0);
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;
   assign out_data = mem_r[rd_ptr_r];

   // storage write
   always_ff @(posedge sys_clk) begin
      if (push) begin
         mem_r[wr_ptr_r] <= in_data;
      end
   end

   // pointers and fill count
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
         count_r <= '0;
      end else begin
         if (push) begin
            wr_ptr_r <= (wr_ptr_r == PW'(DEPTH - 1)) ? '0 : wr_ptr_r + 1'b1;
         end
         if (pop) begin
            rd_ptr_r <= (rd_ptr_r == PW'(DEPTH - 1)) ? '0 : rd_ptr_r + 1'b1;
         end
         if (push && !pop) begin
            count_r <= count_r + 1'b1;
         end else if (pop && !push) begin
            count_r <= count_r - 1'b1;
         end
      end
   end

endmodule : pshx_fifo

// ==== pshx_top.sv ====
// pshx_top: formats raw pressure scans into ascii hex lines on the remote serial output,
// and shares that port with the converted value stream, which a cr/lf line from the host halts
// assumes scan strobes and converted bytes come from logic on sys_clk; serial_rx is a pin
`timescale 1ns/100ps

// Behaviour
// - at most one pressure line per instrument scan strobe
// - each frequency byte sent as two hex characters
// - every line ends with cr then lf
// - first six characters are frequency bytes
// - next three characters are temperature compensation
// - bit rate selectable 1200 to 19200 baud
// - averaging never alters pressure line rate
// - converted stream starts running after reset
// - received cr lf line halts converted stream
// - full duplex, eight data bits, no parity
module pshx_top
   import pshx_pkg::*;
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic sys_rst,
   // raw scan input, one strobe per instrument scan
   input wire logic scan_stb,
   input wire pshx_pkg::pshx_scan_s scan_data,
   // configuration
   input wire logic [2:0] pressure_line_rate_cmd,
   // converted value stream bytes
   input wire logic cvs_valid,
   output logic cvs_ready,
   input wire logic [7:0] cvs_data,
   output logic converted_value_stream_run,
   // serial pins
   input wire logic serial_rx,
   output logic serial_tx
);
   import pshx_pkg::*;

   // ------------------------------------------------------------
   // declarations
   // ------------------------------------------------------------
   pshx_scan_s pend_scan_r;
   pshx_scan_s line_scan_r;
   logic pend_r;
   logic line_busy_r;
   logic [3:0] idx_r;
   logic run_r;
   logic [DIV_W-1:0] div_r;
   logic fifo_in_valid;
   logic fifo_in_ready;
   logic [7:0] fifo_in_data;
   logic fifo_out_valid;
   logic fifo_out_ready;
   logic [7:0] fifo_out_data;
   logic line_start;
   logic cvs_take;
   pshx_tx_e tx_state_r;
   logic [DIV_W-1:0] tx_cnt_r;
   logic [3:0] tx_bit_r;
   logic [7:0] tx_shift_r;
   logic tx_r;
   logic rx_s1_r;
   logic rx_s2_r;
   pshx_rx_e rx_state_r;
   logic [DIV_W-1:0] rx_cnt_r;
   logic [3:0] rx_bit_r;
   logic [7:0] rx_shift_r;
   logic prev_cr_r;

   // character for a position in the line
   function automatic logic [7:0] line_char(input pshx_scan_s s, input logic [3:0] i);
      case (i)
         4'h0: line_char = pshx_hex(s.freq_hi[7:4]);
         4'h1: line_char = pshx_hex(s.freq_hi[3:0]);
         4'h2: line_char = pshx_hex(s.freq_lo[7:4]);
         4'h3: line_char = pshx_hex(s.freq_lo[3:0]);
         4'h4: line_char = pshx_hex(s.freq_frac[7:4]);
         4'h5: line_char = pshx_hex(s.freq_frac[3:0]);
         4'h6: line_char = pshx_hex(s.temp_comp[11:8]);
         4'h7: line_char = pshx_hex(s.temp_comp[7:4]);
         4'h8: line_char = pshx_hex(s.temp_comp[3:0]);
         IDX_CR: line_char = CHAR_CR;
         default: line_char = CHAR_LF;
      endcase
   endfunction : line_char

   // ------------------------------------------------------------
   // scan capture and line sequencing
   // ------------------------------------------------------------
   // a pending scan waits for the current line; a newer strobe replaces it
   assign line_start = pend_r && !line_busy_r;

   // every strobe latches its scan as pending regardless of any averaging elsewhere; a newer strobe overwrites it
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         pend_r <= 1'b0;
         pend_scan_r <= '0;
      end else begin
         if (scan_stb) begin
            pend_r <= 1'b1;
            pend_scan_r <= scan_data;
         end else if (line_start) begin
            pend_r <= 1'b0;
         end
      end
   end

   // line copy and character index, held until the lf is queued
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         line_busy_r <= 1'b0;
         line_scan_r <= '0;
         idx_r <= '0;
      end else if (line_start) begin
         line_busy_r <= 1'b1;
         line_scan_r <= pend_scan_r;
         idx_r <= '0;
      end else if (line_busy_r && fifo_in_ready) begin
         if (idx_r == LINE_LAST) begin
            line_busy_r <= 1'b0;
         end
         idx_r <= idx_r + 1'b1;
      end
   end

   // converted bytes only go between pressure lines
   assign cvs_take = run_r && !line_busy_r && !pend_r && fifo_in_ready;
   assign cvs_ready = cvs_take;
   assign fifo_in_valid = line_busy_r || (cvs_take && cvs_valid);
   assign fifo_in_data = line_busy_r ? line_char(line_scan_r, idx_r) : cvs_data;
   assign converted_value_stream_run = run_r;

   // ------------------------------------------------------------
   // character buffer
   // ------------------------------------------------------------
   pshx_fifo #(
      .WIDTH(CHAR_W),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .sys_clk(sys_clk),
      .sys_rst(sys_rst),
      .in_valid(fifo_in_valid),
      .in_ready(fifo_in_ready),
      .in_data(fifo_in_data),
      .out_valid(fifo_out_valid),
      .out_ready(fifo_out_ready),
      .out_data(fifo_out_data)
   );

   // ------------------------------------------------------------
   // bit period
   // ------------------------------------------------------------
   // registered divisor for the selected line rate
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         div_r <= DIV_9600;
      end else begin
         div_r <= pshx_div(pressure_line_rate_cmd);
      end
   end

   // ------------------------------------------------------------
   // serial transmitter, 8 data bits, no parity, one stop
   // ------------------------------------------------------------
   assign fifo_out_ready = (tx_state_r == PSHX_TX_IDLE);
   assign serial_tx = tx_r;

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         tx_state_r <= PSHX_TX_IDLE;
         tx_cnt_r <= '0;
         tx_bit_r <= '0;
         tx_shift_r <= '0;
         tx_r <= 1'b1;
      end else begin
         case (tx_state_r)
            PSHX_TX_IDLE: begin
               tx_r <= 1'b1;
               if (fifo_out_valid) begin
                  tx_shift_r <= fifo_out_data;
                  tx_cnt_r <= div_r - 1'b1;
                  tx_r <= 1'b0;
                  tx_state_r <= PSHX_TX_START;
               end
            end
            PSHX_TX_START, PSHX_TX_DATA: begin
               if (tx_cnt_r != '0) begin
                  tx_cnt_r <= tx_cnt_r - 1'b1;
               end else begin
                  tx_cnt_r <= div_r - 1'b1;
                  if (tx_state_r == PSHX_TX_START) begin
                     tx_bit_r <= '0;
                     tx_r <= tx_shift_r[0];
                     tx_state_r <= PSHX_TX_DATA;
                  end else if (tx_bit_r == BIT_LAST) begin
                     tx_r <= 1'b1;
                     tx_state_r <= PSHX_TX_STOP;
                  end else begin
                     tx_bit_r <= tx_bit_r + 1'b1;
                     tx_r <= tx_shift_r[tx_bit_r[2:0] + 3'h1];
                  end
               end
            end
            PSHX_TX_STOP: begin
               if (tx_cnt_r != '0) begin
                  tx_cnt_r <= tx_cnt_r - 1'b1;
               end else begin
                  tx_state_r <= PSHX_TX_IDLE;
               end
            end
            default: tx_state_r <= PSHX_TX_IDLE;
         endcase
      end
   end

   // ------------------------------------------------------------
   // serial receiver for the halt line
   // ------------------------------------------------------------
   // two-stage synchroniser on the pin
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         rx_s1_r <= 1'b1;
         rx_s2_r <= 1'b1;
      end else begin
         rx_s1_r <= serial_rx;
         rx_s2_r <= rx_s1_r;
      end
   end

   // mid-bit sampling, runs while transmitting
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         rx_state_r <= PSHX_RX_IDLE;
         rx_cnt_r <= '0;
         rx_bit_r <= '0;
         rx_shift_r <= '0;
      end else begin
         case (rx_state_r)
            PSHX_RX_IDLE: begin
               if (!rx_s2_r) begin
                  rx_cnt_r <= div_r >> 1;
                  rx_state_r <= PSHX_RX_START;
               end
            end
            PSHX_RX_START: begin
               if (rx_cnt_r != '0) begin
                  rx_cnt_r <= rx_cnt_r - 1'b1;
               end else if (rx_s2_r) begin
                  rx_state_r <= PSHX_RX_IDLE;
               end else begin
                  rx_cnt_r <= div_r - 1'b1;
                  rx_bit_r <= '0;
                  rx_state_r <= PSHX_RX_DATA;
               end
            end
            PSHX_RX_DATA: begin
               if (rx_cnt_r != '0) begin
                  rx_cnt_r <= rx_cnt_r - 1'b1;
               end else begin
                  rx_cnt_r <= div_r - 1'b1;
                  rx_shift_r <= {rx_s2_r, rx_shift_r[7:1]};
                  rx_bit_r <= rx_bit_r + 1'b1;
                  if (rx_bit_r == BIT_LAST) begin
                     rx_state_r <= PSHX_RX_STOP;
                  end
               end
            end
            PSHX_RX_STOP: begin
               if (rx_cnt_r != '0) begin
                  rx_cnt_r <= rx_cnt_r - 1'b1;
               end else begin
                  rx_state_r <= PSHX_RX_IDLE;
               end
            end
            default: rx_state_r <= PSHX_RX_IDLE;
         endcase
      end
   end

   // stream runs from reset, halts on cr immediately followed by lf
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         run_r <= 1'b1;
         prev_cr_r <= 1'b0;
      end else if (rx_state_r == PSHX_RX_STOP && rx_cnt_r == '0 && rx_s2_r) begin
         prev_cr_r <= (rx_shift_r == CHAR_CR);
         if (prev_cr_r && rx_shift_r == CHAR_LF) begin
            run_r <= 1'b0;
         end
      end
   end

endmodule : pshx_top

// ==== pshx_top_monitor.sv ====
// pshx_top_monitor: pin-level assertions for pshx_top
// assumes it is bound into pshx_top, one clock, synchronous reset
`timescale 1ns/100ps
module pshx_top_monitor
   import pshx_pkg::*;
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic sys_rst,
   // scan and stream side
   input wire logic scan_stb,
   input wire pshx_pkg::pshx_scan_s scan_data,
   input wire logic [2:0] pressure_line_rate_cmd,
   input wire logic cvs_valid,
   input wire logic cvs_ready,
   input wire logic [7:0] cvs_data,
   input wire logic converted_value_stream_run,
   // serial pins
   input wire logic serial_rx,
   input wire logic serial_tx
);
   // ------
   // helpers and checks
   // ------
   int div;
   int low_run_r;
   int high_run_r;
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (sys_rst);
   // bit period of the selected rate
   always_comb begin
      case (pressure_line_rate_cmd)
         RATE_1200: div = int'(DIV_1200);
         RATE_2400: div = int'(DIV_2400);
         RATE_4800: div = int'(DIV_4800);
         RATE_19200: div = int'(DIV_19200);
         default: div = int'(DIV_9600);
      endcase
   end
   // length of the present low run on the line
   always_ff @(posedge sys_clk) begin
      if (sys_rst || serial_tx) begin
         low_run_r <= 0;
      end else begin
         low_run_r <= low_run_r + 1;
      end
   end
   // length of the present high run, saturating
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         high_run_r <= 1000000;
      end else if (!serial_tx) begin
         high_run_r <= 0;
      end else if (high_run_r < 1000000) begin
         high_run_r <= high_run_r + 1;
      end
   end
   sequence s_quiet_scan;
      scan_stb && !cvs_valid && high_run_r > 10 * div;
   endsequence
   sequence s_halted;
      !converted_value_stream_run;
   endsequence
   AST_LINE_START: assert property (s_quiet_scan |-> ##[1:12] !serial_tx)
      else $error("no start bit after scan strobe");
   AST_LINE_PRIO: assert property (scan_stb |=> !cvs_ready [*8])
      else $error("stream byte accepted while a line is pending");
   AST_MIN_LOW: assert property ($rose(serial_tx) |-> low_run_r >= div)
      else $error("low run shorter than one bit");
   AST_MAX_LOW: assert property (!serial_tx |-> low_run_r < 9 * div)
      else $error("low run longer than nine bits");
   AST_STOP_LEN: assert property ($fell(serial_tx) |-> high_run_r >= div)
      else $error("stop bit shorter than one bit");
   AST_RST_RUN: assert property ($fell(sys_rst) |-> converted_value_stream_run && serial_tx)
      else $error("stream not running or line not idle after reset");
   AST_HALT_HOLD: assert property (s_halted |=> s_halted)
      else $error("halted stream restarted");
   AST_READY_RUN: assert property (cvs_ready |-> converted_value_stream_run)
      else $error("stream byte accepted while halted");
endmodule : pshx_top_monitor

bind pshx_top pshx_top_monitor MON (.sys_clk(sys_clk), .sys_rst(sys_rst), .scan_stb(scan_stb),
   .scan_data(scan_data), .pressure_line_rate_cmd(pressure_line_rate_cmd), .cvs_valid(cvs_valid),
   .cvs_ready(cvs_ready), .cvs_data(cvs_data), .converted_value_stream_run(converted_value_stream_run),
   .serial_rx(serial_rx), .serial_tx(serial_tx));

// ==== pshx_host_model.sv ====
// pshx_host_model: behavioural serial host on the remote output pins
// assumes 8n1 framing at a fixed bit period of DIV system clocks
`timescale 1ns/100ps
module pshx_host_model #(
   parameter int DIV = 2083
) (
   // clock
   input wire logic sys_clk,
   // serial pins seen from the host
   input wire logic serial_tx,
   output logic serial_rx
);
   // ------
   // receive and transmit
   // ------
   logic [7:0] rx_q [$];
   logic frame_err_r;
   logic [7:0] rx_byte;
   // decode lsb first, sampling mid-bit, stop bit must be high
   initial begin
      frame_err_r = 1'b0;
      forever begin
         @(negedge serial_tx);
         repeat (DIV / 2) @(posedge sys_clk);
         for (int i = 0; i < 8; i++) begin
            repeat (DIV) @(posedge sys_clk);
            rx_byte[i] = serial_tx;
         end
         repeat (DIV) @(posedge sys_clk);
         if (serial_tx !== 1'b1) begin
            frame_err_r = 1'b1;
         end else begin
            rx_q.push_back(rx_byte);
         end
      end
   end
   // start, eight data bits lsb first, stop, no parity
   task automatic send_byte(input logic [7:0] b);
      logic [9:0] frame;
      frame = {1'b1, b, 1'b0};
      for (int i = 0; i < 10; i++) begin
         @(posedge sys_clk);
         serial_rx <= frame[i];
         repeat (DIV - 1) @(posedge sys_clk);
      end
   endtask : send_byte
   // idle line level
   initial serial_rx = 1'b1;
endmodule : pshx_host_model

// ==== pshx_top_test.sv ====
// pshx_top_test: self-checking bench for pshx_top against a serial host model
// assumes the package, fifo, top, monitor and host model are compiled first
`timescale 1ns/100ps
module pshx_top_test;
   import pshx_pkg::*;
   // ------
   // stimulus, instances and checks
   // ------
   logic sys_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic scan_stb = 1'b0;
   pshx_scan_s scan_data = '0;
   logic [2:0] rate = RATE_19200;
   logic cvs_valid = 1'b0;
   logic [7:0] cvs_data = 8'h00;
   logic cvs_ready;
   logic run;
   logic serial_rx;
   logic serial_tx;
   int bad_count = 0;
   int n_checks = 0;
   logic [7:0] exp_q [$];
   pshx_top DUT (.sys_clk(sys_clk), .sys_rst(sys_rst), .scan_stb(scan_stb), .scan_data(scan_data),
      .pressure_line_rate_cmd(rate), .cvs_valid(cvs_valid), .cvs_ready(cvs_ready), .cvs_data(cvs_data),
      .converted_value_stream_run(run), .serial_rx(serial_rx), .serial_tx(serial_tx));
   pshx_host_model #(.DIV(int'(DIV_19200))) HOST (.sys_clk(sys_clk), .serial_tx(serial_tx),
      .serial_rx(serial_rx));
   // 40 mhz clock
   initial begin
      forever #12.5 sys_clk = ~sys_clk;
   end
   task automatic chk_char(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk_char
   task automatic chk_bit(input logic got, input logic exp);
      n_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk_bit
   task automatic chk_len(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk_len
   function automatic logic [7:0] asc(input logic [3:0] n);
      return (n < 4'ha) ? 8'h30 + {4'h0, n} : 8'h37 + {4'h0, n};
   endfunction : asc
   task automatic push_line(input pshx_scan_s s);
      exp_q.push_back(asc(s.freq_hi[7:4]));
      exp_q.push_back(asc(s.freq_hi[3:0]));
      exp_q.push_back(asc(s.freq_lo[7:4]));
      exp_q.push_back(asc(s.freq_lo[3:0]));
      exp_q.push_back(asc(s.freq_frac[7:4]));
      exp_q.push_back(asc(s.freq_frac[3:0]));
      exp_q.push_back(asc(s.temp_comp[11:8]));
      exp_q.push_back(asc(s.temp_comp[7:4]));
      exp_q.push_back(asc(s.temp_comp[3:0]));
      exp_q.push_back(8'h0d);
      exp_q.push_back(8'h0a);
   endtask : push_line
   task automatic do_reset();
      @(posedge sys_clk);
      sys_rst <= 1'b1;
      repeat (10) @(posedge sys_clk);
      sys_rst <= 1'b0;
   endtask : do_reset
   task automatic cvs_send(input logic [7:0] b);
      int n;
      @(posedge sys_clk);
      cvs_valid <= 1'b1;
      cvs_data <= b;
      n = 0;
      do begin
         @(negedge sys_clk);
         n++;
      end while (cvs_ready !== 1'b1 && n < 200);
      chk_bit(cvs_ready, 1'b1);
      @(posedge sys_clk);
      cvs_valid <= 1'b0;
   endtask : cvs_send
   task automatic wait_rx(input int cnt);
      int n;
      n = 0;
      while (HOST.rx_q.size() < cnt && n < 400000) begin
         @(posedge sys_clk);
         n++;
      end
      chk_bit(HOST.rx_q.size() >= cnt, 1'b1);
   endtask : wait_rx
   // start bit length at every rate code, unknown code falls back
   task automatic t_rates();
      logic [2:0] codes [6] = '{RATE_1200, RATE_2400, RATE_4800, RATE_9600, RATE_19200, 3'h7};
      logic [15:0] divs [6] = '{DIV_1200, DIV_2400, DIV_4800, DIV_9600, DIV_19200, DIV_9600};
      logic [31:0] n;
      for (int i = 0; i < 6; i++) begin
         do_reset();
         rate <= codes[i];
         cvs_send(8'h01);
         n = 0;
         while (serial_tx !== 1'b0 && n < 100) begin
            @(negedge sys_clk);
            n++;
         end
         n = 0;
         while (serial_tx === 1'b0 && n < 40000) begin
            @(negedge sys_clk);
            n++;
         end
         chk_len(n, {16'h0000, divs[i]});
      end
      $display("test rates done");
   endtask : t_rates
   // stream byte flows after reset with no command
   task automatic t_cvs();
      do_reset();
      rate <= RATE_19200;
      repeat (12 * int'(DIV_19200)) @(posedge sys_clk);
      HOST.rx_q.delete();
      HOST.frame_err_r = 1'b0;
      chk_bit(run, 1'b1);
      cvs_send(8'h5a);
      wait_rx(1);
      chk_char(HOST.rx_q[0], 8'h5a);
      $display("test stream done");
   endtask : t_cvs
   // one line, then a strobe mid-line that must wait its turn
   task automatic t_line();
      pshx_scan_s s1;
      pshx_scan_s s2;
      s1 = {8'h80, 8'he8, 8'h81, 12'ha81};
      s2 = {8'h3c, 8'h5b, 8'hf0, 12'h7d2};
      repeat (12 * int'(DIV_19200)) @(posedge sys_clk);
      HOST.rx_q.delete();
      scan_data <= s1;
      scan_stb <= 1'b1;
      @(posedge sys_clk);
      scan_stb <= 1'b0;
      // second strobe while the first line still fills the buffer
      repeat (20) @(posedge sys_clk);
      scan_data <= s2;
      scan_stb <= 1'b1;
      @(posedge sys_clk);
      scan_stb <= 1'b0;
      push_line(s1);
      exp_q.push_back(asc(s2.freq_hi[7:4]));
      wait_rx(12);
      for (int i = 0; i < 12; i++) begin
         chk_char(HOST.rx_q[i], exp_q[i]);
      end
      $display("test line done");
   endtask : t_line
   // only cr directly followed by lf halts, while the tx side keeps sending
   task automatic t_halt();
      logic [7:0] seq [5] = '{8'h0a, 8'h0d, 8'h41, 8'h0d, 8'h0a};
      for (int i = 0; i < 5; i++) begin
         HOST.send_byte(seq[i]);
         repeat (4) @(posedge sys_clk);
         chk_bit(run, (i == 4) ? 1'b0 : 1'b1);
      end
      cvs_valid <= 1'b1;
      repeat (3) @(negedge sys_clk);
      chk_bit(cvs_ready, 1'b0);
      @(posedge sys_clk);
      cvs_valid <= 1'b0;
      chk_bit(HOST.frame_err_r, 1'b0);
      $display("test halt done");
   endtask : t_halt
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : end_of_test
   // main sequence
   initial begin
      do_reset();
      @(negedge sys_clk);
      chk_bit(serial_tx, 1'b1);
      t_rates();
      t_cvs();
      t_line();
      t_halt();
      end_of_test();
   end
   // watchdog, well beyond the expected run of about 12 ms
   initial begin
      #20000000;
      bad_count++;
      $display("watchdog expired");
      end_of_test();
   end
endmodule : pshx_top_test
